// File: logic/lvct_top.sv
`timescale 1ns/1ns
// Summary of operation
// - Low voltage mode 1, select 000: clock /32, wait 4, convert 80, delay 4.
// - Low voltage mode 1, select 001: clock /16, wait 4, convert 80, delay 4.
// - Divide-by-two low voltage setting: wait 4, convert 107, delay 4.
// - Undivided low voltage setting: wait 6, convert 107, delay 4.
// - Hardware triggered follow-on sequential or scan 1-3 conversions skip the wait.
// - Interrupt delay as listed in one-shot, three clocks shorter in sequential.
module lvct_top
	import lvct_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic [31:0]      o_prdata,
	output logic             o_pslverr,
	// converter events
	input  wire logic        i_hw_trigger,
	output logic             o_conv_end,
	output logic             o_busy,
	output logic             o_irq
);
	// control register state
	logic                start_ff, enable_ff, lsp_ff, seq_ff, scan_ff, hwtrig_ff;
	logic                nxt_start, nxt_enable, nxt_lsp, nxt_seq, nxt_scan, nxt_hwtrig;
	logic [2:0]          fr_ff, nxt_fr;
	logic [1:0]          lv_ff, nxt_lv;
	logic [EV_NUM-1:0]   stat_ff, nxt_stat, mask_ff, nxt_mask;
	logic [3:0]          guard_ff, nxt_guard;
	logic                pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, irq_ff, nxt_irq;
	logic [31:0]         prdata_ff, nxt_prdata;
	// sequencer state
	lvct_phase_type      phase_ff, nxt_phase;
	logic [6:0]          cnt_ff, nxt_cnt;
	logic [1:0]          idx_ff, nxt_idx;
	logic                first_ff, nxt_first, conv_end_ff, nxt_conv_end, busy_ff, nxt_busy;
	// decoded setting and handshakes
	logic                cfg_ok, run, fad_tick, done_ev, stop_req, wr_hit, ctrl_wr, fields_diff;
	logic                seterr_ev, addr_ok;
	logic [4:0]          div_last;
	logic [6:0]          stab_n, conv_n, idly_n, target;
	logic [EV_NUM-1:0]   events;

	// setting decode: divider and phase lengths per field combination
	always_comb begin
		cfg_ok   = 1'b0;
		div_last = DIV32_LAST;
		stab_n   = STAB_CYC;
		conv_n   = CONV_SLOW_CYC;
		if (lv_ff == LV_MODE1) begin
			if (!lsp_ff && fr_ff == FR_DIV32) begin
				cfg_ok   = 1'b1;
				div_last = DIV32_LAST;
			end
			if (!lsp_ff && fr_ff == FR_DIV16) begin
				cfg_ok   = 1'b1;
				div_last = DIV16_LAST;
			end
			if (lsp_ff && fr_ff == FR_DIV2) begin
				cfg_ok   = 1'b1;
				div_last = DIV2_LAST;
				conv_n   = CONV_FAST_CYC;
			end
			if (lsp_ff && fr_ff == FR_DIV1) begin
				cfg_ok   = 1'b1;
				div_last = DIV1_LAST;
				stab_n   = STAB_FAST_CYC;
				conv_n   = CONV_FAST_CYC;
			end
		end
	end

	assign idly_n = seq_ff ? (IDLY_CYC - IDLY_SEQ_CUT) : IDLY_CYC;
	assign run    = start_ff & enable_ff & cfg_ok;

	// conversion clock enable
	lvct_fad_div u_fad_div (
		.i_ref_clk  (i_ref_clk),
		.i_rst      (i_rst),
		.i_run      (phase_ff != PH_IDLE),
		.i_div_last (div_last),
		.o_tick     (fad_tick)
	);

	// phase length select
	always_comb begin
		case (phase_ff)
			PH_STAB: target = stab_n;
			PH_CONV: target = conv_n;
			PH_IDLY: target = idly_n;
			default: target = 7'h01;
		endcase
	end

	// sequencer: wait, convert, interrupt delay
	always_comb begin
		nxt_phase    = phase_ff;
		nxt_cnt      = cnt_ff;
		nxt_idx      = idx_ff;
		nxt_first    = first_ff;
		nxt_conv_end = 1'b0;
		done_ev      = 1'b0;
		stop_req     = 1'b0;
		case (phase_ff)
			PH_IDLE: begin
				nxt_cnt = 7'h00;
				if (!run) begin
					nxt_first = 1'b1;
					nxt_idx   = 2'h0;
				end else if (!hwtrig_ff || i_hw_trigger) begin
					if (hwtrig_ff && ((seq_ff && !first_ff) || (scan_ff && idx_ff != 2'h0))) begin
						nxt_phase = PH_CONV;
					end else begin
						nxt_phase = PH_STAB;
					end
				end
			end
			PH_STAB, PH_CONV, PH_IDLY: begin
				if (!run) begin
					nxt_phase = PH_IDLE;
					nxt_first = 1'b1;
					nxt_idx   = 2'h0;
				end else if (fad_tick) begin
					if (cnt_ff == target - 7'h01) begin
						nxt_cnt = 7'h00;
						if (phase_ff == PH_STAB) begin
							nxt_phase = PH_CONV;
						end else if (phase_ff == PH_CONV) begin
							nxt_phase = PH_IDLY;
						end else begin
							nxt_phase    = PH_IDLE;
							nxt_conv_end = 1'b1;
							done_ev      = 1'b1;
							nxt_first    = 1'b0;
							nxt_idx      = scan_ff ? idx_ff + 2'h1 : 2'h0;
							stop_req     = !seq_ff && (!scan_ff || idx_ff == SCAN_LAST_IDX);
						end
					end else begin
						nxt_cnt = cnt_ff + 7'h01;
					end
				end
			end
			default: begin
				nxt_phase = PH_IDLE;
			end
		endcase
		nxt_busy = nxt_phase != PH_IDLE;
	end

	// register the sequencer
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			phase_ff    <= PH_IDLE;
			cnt_ff      <= 7'h00;
			idx_ff      <= 2'h0;
			first_ff    <= 1'b1;
			conv_end_ff <= 1'b0;
			busy_ff     <= 1'b0;
		end else begin
			phase_ff    <= nxt_phase;
			cnt_ff      <= nxt_cnt;
			idx_ff      <= nxt_idx;
			first_ff    <= nxt_first;
			conv_end_ff <= nxt_conv_end;
			busy_ff     <= nxt_busy;
		end
	end

	// apb decode: one wait state, access completes on the second access cycle
	assign addr_ok     = (i_paddr == OFS_CTRL) || (i_paddr == OFS_STAT) ||
	                     (i_paddr == OFS_MASK) || (i_paddr == OFS_STATE);
	assign wr_hit      = i_psel & i_penable & pready_ff & i_pwrite & addr_ok;
	assign ctrl_wr     = wr_hit && i_paddr == OFS_CTRL;
	assign fields_diff = (i_pwdata[CTRL_FR_POS +: 3] != fr_ff) || (i_pwdata[CTRL_LV_POS +: 2] != lv_ff);
	assign seterr_ev   = ctrl_wr & fields_diff & (start_ff | enable_ff | (guard_ff != 4'h0));
	assign events      = {(start_ff & enable_ff & ~cfg_ok), seterr_ev, done_ev};

	// register file next state
	always_comb begin
		nxt_start   = stop_req ? 1'b0 : start_ff;
		nxt_enable  = enable_ff;
		nxt_lsp     = lsp_ff;
		nxt_seq     = seq_ff;
		nxt_scan    = scan_ff;
		nxt_hwtrig  = hwtrig_ff;
		nxt_fr      = fr_ff;
		nxt_lv      = lv_ff;
		nxt_mask    = mask_ff;
		nxt_stat    = stat_ff;
		nxt_pready  = i_psel & i_penable & ~pready_ff;
		nxt_pslverr = i_psel & i_penable & ~pready_ff & ~addr_ok;
		nxt_prdata  = DATA_RST;
		if (ctrl_wr) begin
			nxt_start  = i_pwdata[CTRL_START_POS];
			nxt_enable = i_pwdata[CTRL_ENABLE_POS];
			nxt_lsp    = i_pwdata[CTRL_LSP_POS];
			nxt_seq    = i_pwdata[CTRL_SEQ_POS];
			nxt_scan   = i_pwdata[CTRL_SCAN_POS];
			nxt_hwtrig = i_pwdata[CTRL_HWTRIG_POS];
			if (!seterr_ev) begin
				nxt_fr = i_pwdata[CTRL_FR_POS +: 3];
				nxt_lv = i_pwdata[CTRL_LV_POS +: 2];
			end
		end
		if (wr_hit && i_paddr == OFS_MASK) begin
			nxt_mask = i_pwdata[EV_NUM-1:0];
		end
		// write one to clear; a new event wins
		if (wr_hit && i_paddr == OFS_STAT) begin
			nxt_stat = stat_ff & ~i_pwdata[EV_NUM-1:0];
		end
		nxt_stat = nxt_stat | events;
		nxt_irq  = |(nxt_stat & mask_ff);
		if (start_ff && !nxt_start) begin
			nxt_guard = STOP_GUARD_CYC;
		end else if (guard_ff != 4'h0) begin
			nxt_guard = guard_ff - 4'h1;
		end else begin
			nxt_guard = guard_ff;
		end
		// read data prepared on the first access cycle
		if (i_psel && i_penable && !pready_ff && !i_pwrite) begin
			case (i_paddr)
				OFS_CTRL: begin
					nxt_prdata[CTRL_START_POS]     = start_ff;
					nxt_prdata[CTRL_ENABLE_POS]    = enable_ff;
					nxt_prdata[CTRL_LSP_POS]       = lsp_ff;
					nxt_prdata[CTRL_SEQ_POS]       = seq_ff;
					nxt_prdata[CTRL_SCAN_POS]      = scan_ff;
					nxt_prdata[CTRL_HWTRIG_POS]    = hwtrig_ff;
					nxt_prdata[CTRL_FR_POS +: 3]   = fr_ff;
					nxt_prdata[CTRL_LV_POS +: 2]   = lv_ff;
				end
				OFS_STAT: nxt_prdata[EV_NUM-1:0] = stat_ff;
				OFS_MASK: nxt_prdata[EV_NUM-1:0] = mask_ff;
				OFS_STATE: nxt_prdata[16:0] = {guard_ff, cfg_ok, first_ff, idx_ff, phase_ff, cnt_ff};
				default: nxt_prdata = DATA_RST;
			endcase
		end
	end

	// register the register file
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			start_ff   <= 1'b0;
			enable_ff  <= 1'b0;
			lsp_ff     <= 1'b0;
			seq_ff     <= 1'b0;
			scan_ff    <= 1'b0;
			hwtrig_ff  <= 1'b0;
			fr_ff      <= FR_RST;
			lv_ff      <= LV_RST;
			mask_ff    <= MASK_RST;
			stat_ff    <= '0;
			guard_ff   <= 4'h0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= DATA_RST;
			irq_ff     <= 1'b0;
		end else begin
			start_ff   <= nxt_start;
			enable_ff  <= nxt_enable;
			lsp_ff     <= nxt_lsp;
			seq_ff     <= nxt_seq;
			scan_ff    <= nxt_scan;
			hwtrig_ff  <= nxt_hwtrig;
			fr_ff      <= nxt_fr;
			lv_ff      <= nxt_lv;
			mask_ff    <= nxt_mask;
			stat_ff    <= nxt_stat;
			guard_ff   <= nxt_guard;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff  <= nxt_prdata;
			irq_ff     <= nxt_irq;
		end
	end

	// outputs straight from flops
	assign o_pready   = pready_ff;
	assign o_prdata   = prdata_ff;
	assign o_pslverr  = pslverr_ff;
	assign o_irq      = irq_ff;
	assign o_conv_end = conv_end_ff;
	assign o_busy     = busy_ff;
endmodule // lvct_top

// File: logic/lvct_pkg.sv
// shared constants for the low voltage conversion timing block
package lvct_pkg;

	// apb register byte offsets
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_STAT  = 8'h04;
	localparam logic [7:0] OFS_MASK  = 8'h08;
	localparam logic [7:0] OFS_STATE = 8'h0C;

	// control register field positions
	localparam int CTRL_START_POS  = 0;
	localparam int CTRL_ENABLE_POS = 1;
	localparam int CTRL_LSP_POS    = 2;
	localparam int CTRL_SEQ_POS    = 3;
	localparam int CTRL_SCAN_POS   = 4;
	localparam int CTRL_HWTRIG_POS = 5;
	localparam int CTRL_FR_POS     = 8;
	localparam int CTRL_LV_POS     = 12;

	// status and mask bit positions
	localparam int EV_DONE_POS   = 0;
	localparam int EV_SETERR_POS = 1;
	localparam int EV_BADCFG_POS = 2;
	localparam int EV_NUM        = 3;

	// reset values
	localparam logic [2:0]  FR_RST   = 3'h0;
	localparam logic [1:0]  LV_RST   = 2'h0;
	localparam logic [2:0]  MASK_RST = 3'h0;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;

	// accepted field combinations
	localparam logic [1:0] LV_MODE1   = 2'h2;
	localparam logic [2:0] FR_DIV32   = 3'h0;
	localparam logic [2:0] FR_DIV16   = 3'h1;
	localparam logic [2:0] FR_DIV2    = 3'h4;
	localparam logic [2:0] FR_DIV1    = 3'h5;

	// divider terminal counts (divide ratio minus one)
	localparam logic [4:0] DIV32_LAST = 5'h1F;
	localparam logic [4:0] DIV16_LAST = 5'h0F;
	localparam logic [4:0] DIV2_LAST  = 5'h01;
	localparam logic [4:0] DIV1_LAST  = 5'h00;

	// phase lengths in conversion clocks
	localparam logic [6:0] STAB_CYC      = 7'h04;
	localparam logic [6:0] STAB_FAST_CYC = 7'h06;
	localparam logic [6:0] CONV_SLOW_CYC = 7'h50;
	localparam logic [6:0] CONV_FAST_CYC = 7'h6B;
	localparam logic [6:0] IDLY_CYC      = 7'h04;
	localparam logic [6:0] IDLY_SEQ_CUT  = 7'h03;
	localparam logic [1:0] SCAN_LAST_IDX = 2'h3;

	// settle time after stopping before fields may change
	localparam int CLK_PERIOD_NS  = 20;
	localparam int STOP_GUARD_NS  = 200;
	localparam logic [3:0] STOP_GUARD_CYC = 4'((STOP_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// sequencer phases
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_STAB,
		PH_CONV,
		PH_IDLY
	} lvct_phase_type;

endpackage

// File: logic/lvct_fad_div.sv
`timescale 1ns/1ns
// conversion clock enable: one pulse every (i_div_last + 1) clocks while running
module lvct_fad_div (
	// clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	// control
	input  wire logic       i_run,
	input  wire logic [4:0] i_div_last,
	// conversion clock enable
	output logic            o_tick
);
	logic [4:0] cnt_ff;
	logic [4:0] nxt_cnt;
	logic       tick_ff;
	logic       nxt_tick;

	// restart the count whenever idle so phases align to the start
	always_comb begin
		nxt_cnt  = 5'h00;
		nxt_tick = 1'b0;
		if (i_run) begin
			if (cnt_ff >= i_div_last) begin
				nxt_tick = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + 5'h01;
			end
		end
	end

	// register the divider
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_ff  <= 5'h00;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign o_tick = tick_ff;
endmodule // lvct_fad_div

// File: bench/lvct_top_asserts.sv
`timescale 1ns/1ns
// port-level checks for bus handshake and conversion pulses
module lvct_top_asserts (
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	// apb
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        o_pready,
	input  wire logic [31:0] o_prdata,
	input  wire logic        o_pslverr,
	// converter
	input  wire logic        o_conv_end,
	input  wire logic        o_busy
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	// access phase start and conversion start
	sequence s_access;
		i_psel && $rose(i_penable);
	endsequence
	sequence s_start;
		$rose(o_busy);
	endsequence
	a_pready_pulse: assert property (o_pready |=> !o_pready)
		else $error("ready held longer than one cycle");
	a_pready_wait: assert property (s_access |-> !o_pready ##1 o_pready)
		else $error("ready not in second access cycle");
	a_prdata_zero: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data outside answer cycle");
	a_slverr_qual: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	a_end_pulse: assert property (o_conv_end |=> !o_conv_end)
		else $error("end pulse wider than one cycle");
	a_end_busy: assert property (o_conv_end |-> $past(o_busy))
		else $error("end pulse without a running conversion");
	a_end_early: assert property (s_start |-> !o_conv_end [*8])
		else $error("end pulse too soon after start");
	a_idle_quiet: assert property (!o_busy && !$past(o_busy) |-> !o_conv_end)
		else $error("end pulse while idle");
endmodule // lvct_top_asserts

bind lvct_top lvct_top_asserts u_chk (
	.i_ref_clk (i_ref_clk),
	.i_rst     (i_rst),
	.i_psel    (i_psel),
	.i_penable (i_penable),
	.o_pready  (o_pready),
	.o_prdata  (o_prdata),
	.o_pslverr (o_pslverr),
	.o_conv_end(o_conv_end),
	.o_busy    (o_busy)
);

// File: bench/lvct_top_tb_top.sv
`timescale 1ns/1ns
// self-checking bench for the conversion timing block
module lvct_top_tb_top
	import lvct_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic        trig = 1'b0;
	logic [7:0]  pa = 8'h00;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prd;
	logic        rdy;
	logic        serr;
	logic        cend;
	logic        busy;
	logic        irq;
	logic [31:0] rd;
	logic        er;
	int          failures = 0;
	int          comparisons = 0;
	int          t;
	int          p1;
	int          ts [4];
	// rows: control word, expected cycles to end pulse
	// listed combinations only
	logic [31:0] cfg [4] = '{32'h0000_2000, 32'h0000_2100, 32'h0000_2404, 32'h0000_2504};
	int          tot [4] = '{2816, 1408, 230, 117};

	// 50 MHz clock
	always #10 clk = ~clk;

	lvct_top dut (
		.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(pa), .i_pwdata(pwd), .o_pready(rdy), .o_prdata(prd), .o_pslverr(serr),
		.i_hw_trigger(trig), .o_conv_end(cend), .o_busy(busy), .o_irq(irq)
	);

	// compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// verdict and stop
	task automatic end_sim;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// one apb transfer, held until ready is sampled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 40);
		// a missing ready counts as a mismatch
		if (rdy !== 1'b1) begin
			failures++;
		end
		rd = prd;
		er = serr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// count edges until the next end pulse
	task automatic wait_end;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (cend !== 1'b1 && t < 5000);
		// a missing end pulse counts as a mismatch
		if (cend !== 1'b1) begin
			failures++;
		end
	endtask

	// stop, let the guard expire, load fields, start
	task automatic conv(input logic [31:0] c);
		apb(1'b1, OFS_CTRL, 32'h0);
		repeat (12) @(posedge clk);
		apb(1'b1, OFS_CTRL, c);
		apb(1'b1, OFS_CTRL, c | 32'h3);
		wait_end();
	endtask

	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, OFS_CTRL, 32'h0);
		check(rd, DATA_RST);
		apb(1'b0, 8'h10, 32'h0);
		check({31'h0, er}, 32'h1);
		apb(1'b1, OFS_MASK, 32'h1);
		for (int i = 0; i < 4; i++) begin
			conv(cfg[i]);
			ts[i] = t;
			check({31'h0, t >= tot[i] && t <= tot[i] + 4}, 32'h1); // row timing
		end
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, OFS_STAT, 32'h7);
		apb(1'b0, OFS_STAT, 32'h0);
		check(rd, 32'h0);
		check({31'h0, irq}, 32'h0);
		// sequential first result: delay three ticks shorter
		conv(cfg[2] | 32'h8);
		check(32'(ts[2] - t), 32'h6); // shorter delay
		// sequential repeat period with and without wait skipping
		conv(cfg[3] | 32'h8);
		wait_end();
		p1 = t;
		trig <= 1'b1;
		conv(cfg[3] | 32'h28);
		wait_end();
		check(32'(p1 - t), 32'h6); // wait skipped
		// field change while running is refused; stale flags cleared first
		apb(1'b1, OFS_STAT, 32'h7);
		apb(1'b1, OFS_CTRL, cfg[2] | 32'h2B);
		apb(1'b0, OFS_CTRL, 32'h0);
		check({29'h0, rd[10:8]}, {29'h0, FR_DIV1}); // fields kept
		apb(1'b0, OFS_STAT, 32'h0);
		check({31'h0, rd[1]}, 32'h1); // error flagged
		// change right after stopping is refused, later accepted
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_CTRL, cfg[2]);
		apb(1'b0, OFS_CTRL, 32'h0);
		check({29'h0, rd[10:8]}, {29'h0, FR_DIV1}); // guard holds
		check({31'h0, busy}, 32'h0);
		repeat (12) @(posedge clk);
		apb(1'b1, OFS_CTRL, cfg[2]);
		apb(1'b0, OFS_CTRL, 32'h0);
		check({29'h0, rd[10:8]}, {29'h0, FR_DIV2}); // accepted later
		// hardware triggered scan: index 0 waits, indices 1 to 3 skip it
		conv(cfg[2] | 32'h30);
		check({31'h0, t >= tot[2] && t <= tot[2] + 4}, 32'h1); // scan index 0
		wait_end();
		check({31'h0, t >= tot[2] - 8 && t <= tot[2] - 4}, 32'h1); // scan wait skipped
		wait_end();
		wait_end();
		repeat (4) @(posedge clk);
		check({31'h0, busy}, 32'h0);
		apb(1'b0, OFS_CTRL, 32'h0);
		check({31'h0, rd[0]}, 32'h0);
		// unlisted combination: started but never runs, flagged
		apb(1'b1, OFS_CTRL, 32'h0);
		repeat (12) @(posedge clk);
		apb(1'b1, OFS_CTRL, 32'h3);
		repeat (4) @(posedge clk);
		check({31'h0, busy}, 32'h0); // no run
		apb(1'b0, OFS_STAT, 32'h0);
		check({31'h0, rd[2]}, 32'h1); // bad setting flagged
		apb(1'b0, OFS_STATE, 32'h0);
		check(rd, 32'h0000_0800);
		// reset while started on the bad setting returns the control and status registers and the interrupt to their reset values
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		check({31'h0, irq}, 32'h0);
		apb(1'b0, OFS_CTRL, 32'h0);
		check(rd, DATA_RST);
		apb(1'b0, OFS_STAT, 32'h0);
		check(rd, DATA_RST);
		end_sim();
	end

	// watchdog
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		end_sim();
	end
endmodule // lvct_top_tb_top
